// >>> pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic rise_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else if (clk_en) begin
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
    end
  end

  assign level = level_q;
  assign rise  = rise_q;

endmodule : pin_sync

// >>> synth_cfg_pkg.sv
// Types shared by the three-wire configuration loader
package synth_cfg_pkg;

  typedef enum logic [1:0] {
    LATCH_CONTROL = 2'b00,
    LATCH_RCOUNT  = 2'b01,
    LATCH_NCOUNT  = 2'b10,
    LATCH_TEST    = 2'b11
  } latch_sel_e;

  typedef enum logic [1:0] {
    MUX_LOCK    = 2'b00,
    MUX_RF_DIV  = 2'b01,
    MUX_REF_DIV = 2'b10,
    MUX_LOW     = 2'b11
  } mux_sel_e;

  typedef logic [23:0] cfg_word_t;

endpackage : synth_cfg_pkg

// >>> synth_cfg_regs.svh
// Register offsets, field positions and reset values of the loader
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH

`define CFG_WORD_BITS      24
`define OFS_CTRL           12'h000
`define OFS_STATUS         12'h004
`define OFS_LATCH0         12'h008
`define OFS_LATCH1         12'h00c
`define OFS_LATCH2         12'h010
`define OFS_LATCH3         12'h014
`define OFS_SHIFT          12'h018
`define CTRL_MUX_LSB       0
`define CTRL_MUX_MSB       1
`define CTRL_PWR_LSB       2
`define CTRL_PWR_MSB       4
`define CTRL_RESET         32'h0000001c
`define SECTION_COUNT      3
`define BIT_COUNT_MAX      5'h1f

`endif

// >>> synth_three_wire_config_loader.sv
// Three-wire configuration loader with APB status and control access
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"

// Notes on behaviour
// R1 - Each serial clock rising edge shifts the data pin into a 24-bit register.
// R2 - Host sends words MSB first; last two bits are the latch select code.
// R3 - Load strobe rising copies the shift register into exactly one latch.
// R4 - Chip enable low powers down and floats the charge pump output.
// R5 - Chip enable high powers only sections that the enable bits allow.
// R6 - Status mux output drives lock detect, scaled RF or scaled reference.
// R7 - Select code 00 control, 01 R counter, 10 N counter, 11 test latch.
// R8 - Host writes R counter, then control, then N counter at power-up.
// R9 - Host never loads the test modes latch.
// R10 - Latches change only when a load strobe selects them.
module synth_three_wire_config_loader
  import synth_cfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock,
  input  wire logic        serial_data,
  input  wire logic        load_strobe,
  input  wire logic        chip_enable,
  input  wire logic        lock_detect_in,
  input  wire logic        rf_scaled_in,
  input  wire logic        ref_scaled_in,
  input  wire logic        pump_drive,
  output logic             charge_pump_output,
  output logic             charge_pump_oe_n,
  output logic             status_mux_output,
  output logic      [2:0]  section_power
);

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic sclk_lvl;
  logic sclk_rise;
  logic data_lvl;
  logic load_lvl;
  logic load_rise;
  logic ce_lvl;
  logic lock_lvl;
  logic rf_lvl;
  logic ref_lvl;

  pin_sync u_sync_sclk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(serial_clock),
                        .level(sclk_lvl), .rise(sclk_rise));
  pin_sync u_sync_data (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(serial_data),
                        .level(data_lvl), .rise());
  pin_sync u_sync_load (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(load_strobe),
                        .level(load_lvl), .rise(load_rise));
  pin_sync u_sync_ce   (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(chip_enable),
                        .level(ce_lvl), .rise());
  pin_sync u_sync_lock (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(lock_detect_in),
                        .level(lock_lvl), .rise());
  pin_sync u_sync_rf   (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(rf_scaled_in),
                        .level(rf_lvl), .rise());
  pin_sync u_sync_ref  (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .pin(ref_scaled_in),
                        .level(ref_lvl), .rise());

  // ***************************************************
  // Serial shift register
  // ***************************************************
  cfg_word_t  shift_q;
  logic [4:0] bit_count_q;

  // Data and clock share the same synchroniser delay, so the data level seen
  // with the detected clock edge is the one the host set up before that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
    end else if (clk_en && sclk_rise) begin
      shift_q <= {shift_q[`CFG_WORD_BITS-2:0], data_lvl}; // R1 R2
    end
  end

  // Bits since the last load, saturating; a diagnostic for short words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_count_q <= '0;
    end else if (clk_en) begin
      if (load_rise) begin
        bit_count_q <= '0;
      end else if (sclk_rise && bit_count_q != `BIT_COUNT_MAX) begin
        bit_count_q <= bit_count_q + 5'h01;
      end
    end
  end

  // ***************************************************
  // Latch decode and storage
  // ***************************************************
  latch_sel_e sel_now;
  latch_sel_e last_sel_q;
  logic [3:0] load_vec;
  cfg_word_t  latch_val [4];

  assign sel_now = latch_sel_e'(shift_q[1:0]);

  always_comb begin
    load_vec = 4'h0;
    if (load_rise) begin
      case (sel_now) // R7
        LATCH_CONTROL: load_vec = 4'h1;
        LATCH_RCOUNT:  load_vec = 4'h2;
        LATCH_NCOUNT:  load_vec = 4'h4;
        LATCH_TEST:    load_vec = 4'h8;
        default:       load_vec = 4'h0;
      endcase
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_latch
    word_latch #(.W(`CFG_WORD_BITS)) u_latch (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .load    (load_vec[i]), // R3 R10
      .d       (shift_q),
      .q       (latch_val[i])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sel_q <= LATCH_CONTROL;
    end else if (clk_en && load_rise) begin
      last_sel_q <= sel_now;
    end
  end

  // ***************************************************
  // Power, charge pump and status multiplexer
  // ***************************************************
  logic [31:0] ctrl_q;
  logic [2:0]  section_power_q;
  logic        cp_out_q;
  logic        cp_oe_n_q;
  logic        mux_out_q;
  mux_sel_e    mux_sel;

  assign mux_sel = mux_sel_e'(ctrl_q[`CTRL_MUX_MSB:`CTRL_MUX_LSB]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      section_power_q <= '0;
    end else if (clk_en) begin
      section_power_q <= ce_lvl ? ctrl_q[`CTRL_PWR_MSB:`CTRL_PWR_LSB] : 3'h0; // R4 R5
    end
  end

  // Section 0 is the synthesizer core; the pump floats unless it is powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_out_q  <= 1'b0;
      cp_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      cp_oe_n_q <= !(ce_lvl && ctrl_q[`CTRL_PWR_LSB]); // R4
      cp_out_q  <= ce_lvl && ctrl_q[`CTRL_PWR_LSB] && pump_drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_out_q <= 1'b0;
    end else if (clk_en) begin
      case (mux_sel) // R6
        MUX_LOCK:    mux_out_q <= lock_lvl;
        MUX_RF_DIV:  mux_out_q <= rf_lvl;
        MUX_REF_DIV: mux_out_q <= ref_lvl;
        MUX_LOW:     mux_out_q <= 1'b0;
        default:     mux_out_q <= 1'b0;
      endcase
    end
  end

  // ***************************************************
  // APB slave, one wait state
  // ***************************************************
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic        addr_ok;
  logic        access;

  assign access = psel && penable;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0;
    case (paddr)
      `OFS_CTRL:   rd_mux = ctrl_q;
      `OFS_STATUS: rd_mux = {21'h0, section_power_q, bit_count_q, last_sel_q, ce_lvl};
      `OFS_LATCH0: rd_mux = {8'h0, latch_val[0]};
      `OFS_LATCH1: rd_mux = {8'h0, latch_val[1]};
      `OFS_LATCH2: rd_mux = {8'h0, latch_val[2]};
      `OFS_LATCH3: rd_mux = {8'h0, latch_val[3]};
      `OFS_SHIFT:  rd_mux = {8'h0, shift_q};
      default:     addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (clk_en) begin
      pready_q  <= access && !pready_q;
      pslverr_q <= access && !pready_q && !addr_ok;
      if (access && !pready_q && !pwrite) begin
        prdata_q <= addr_ok ? rd_mux : 32'h0;
      end
    end
  end

  // Write lands at the edge where the master sees pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (clk_en && access && pready_q && pwrite && paddr == `OFS_CTRL) begin
      ctrl_q <= {27'h0, pwdata[`CTRL_PWR_MSB:0]};
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign charge_pump_output = cp_out_q;
  assign charge_pump_oe_n   = cp_oe_n_q;
  assign status_mux_output  = mux_out_q;
  assign section_power      = section_power_q;

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence load_ev;
    clk_en && load_rise;
  endsequence

  sequence apb_wait;
    psel && penable && !pready_q && clk_en;
  endsequence

  a_shift_on_edge: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (clk_en && sclk_rise) |=> shift_q == {$past(shift_q[22:0]), $past(data_lvl)})
    else $error("shift register did not take the data bit");

  a_shift_idle: assert property (@(posedge pclk) disable iff (!presetn) // R1
    !(clk_en && sclk_rise) |=> $stable(shift_q))
    else $error("shift register moved without a clock edge");

  a_latch_rcount: assert property (@(posedge pclk) disable iff (!presetn) // R3 R7
    (load_ev and (shift_q[1:0] == 2'b01)) |=> latch_val[1] == $past(shift_q))
    else $error("R counter latch not loaded on code 01");

  a_latch_ncount: assert property (@(posedge pclk) disable iff (!presetn) // R3 R7
    (load_ev and (shift_q[1:0] == 2'b10)) |=> latch_val[2] == $past(shift_q) && $stable(latch_val[0]))
    else $error("N counter load wrong or touched control latch");

  a_one_latch: assert property (@(posedge pclk) disable iff (!presetn) // R3
    load_ev |-> $onehot(load_vec) ##1
      ($past(sel_now) == LATCH_CONTROL || $stable(latch_val[0])) &&
      ($past(sel_now) == LATCH_RCOUNT || $stable(latch_val[1])) &&
      ($past(sel_now) == LATCH_NCOUNT || $stable(latch_val[2])) &&
      ($past(sel_now) == LATCH_TEST || $stable(latch_val[3])))
    else $error("load strobe did not select exactly one latch");

  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !load_ev |=> $stable(latch_val[0]) && $stable(latch_val[1]) && $stable(latch_val[2]) && $stable(latch_val[3]))
    else $error("latch changed without a load strobe");

  a_pump_float: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (clk_en && !ce_lvl) |=> charge_pump_oe_n && section_power == 3'h0)
    else $error("pump driven or sections powered while disabled");

  a_power_gate: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (clk_en && ce_lvl) |=> section_power == $past(ctrl_q[`CTRL_PWR_MSB:`CTRL_PWR_LSB]))
    else $error("powered sections differ from enable bits");

  a_mux_lock: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (clk_en && mux_sel == MUX_LOCK) |=> status_mux_output == $past(lock_lvl))
    else $error("status output does not follow lock detect");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wait |=> pready_q ##1 !(pready_q && clk_en && $past(clk_en)))
    else $error("APB answer not given after one wait state");

  a_mux_ref: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (clk_en && mux_sel == MUX_REF_DIV) |=> status_mux_output == $past(ref_lvl))
    else $error("status output does not follow scaled reference");

  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(shift_q) && $stable(ctrl_q) && $stable(section_power) && $stable(pready_q))
    else $error("state moved while the clock enable was low");

endmodule : synth_three_wire_config_loader

// >>> test_synth_three_wire_config_loader.sv
// Self-checking bench for the three-wire configuration loader
`timescale 1ns/1ps
`include "synth_cfg_regs.svh"
module test_synth_three_wire_config_loader import synth_cfg_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, chip_enable;
  logic        lock_detect_in, rf_scaled_in, ref_scaled_in, pump_drive;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, serial_clock, serial_data, load_strobe, clk_en;
  logic        charge_pump_output, charge_pump_oe_n, status_mux_output;
  logic [2:0]  section_power;
  logic [32:0] exp_q[$];
  logic [23:0] w[3];
  logic [3:0]  r;
  logic        e;
  int          n_fail, check_count, cyc, seed;
  latch_sel_e  order[3] = '{LATCH_RCOUNT, LATCH_CONTROL, LATCH_NCOUNT};

  synth_three_wire_config_loader dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_clock, .serial_data, .load_strobe,
    .chip_enable, .lock_detect_in, .rf_scaled_in, .ref_scaled_in, .pump_drive,
    .charge_pump_output, .charge_pump_oe_n, .status_mux_output, .section_power);
  three_wire_host host (.serial_clock, .serial_data, .load_strobe);

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr) exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask : settle

  // Read answers are matched against the oldest note in order
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check("read", {pslverr, prdata}, 33'h1ffffffff);
      else check("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 65626;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {lock_detect_in, rf_scaled_in, ref_scaled_in, pump_drive} = '0;
    chip_enable = 1'b1;
    clk_en      = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL, {1'b0, `CTRL_RESET});
    rd(12'hffc, 33'h100000000);
    for (int k = 0; k < 3; k++) begin
      w[k] = 24'($random(seed));
      w[k][1:0] = order[k];
      host.send_word(w[k], 1'b1);
    end
    settle();
    for (int k = 0; k < 3; k++) rd(12'(`OFS_LATCH0 + 4 * order[k]), {9'h0, w[k]});
    w[0] = 24'($random(seed));
    w[0][1:0] = LATCH_CONTROL;
    host.send_word(w[0], 1'b0);
    settle();
    rd(`OFS_SHIFT, {9'h0, w[0]});
    rd(`OFS_LATCH0, {9'h0, w[1]});
    rd(`OFS_STATUS, 33'h0000007c5);
    // Frozen logic must ignore a whole loaded word
    clk_en <= 1'b0;
    @(posedge pclk);
    host.send_word({w[2][23:2], 2'b00}, 1'b1);
    @(posedge pclk);
    clk_en <= 1'b1;
    settle();
    rd(`OFS_SHIFT, {9'h0, w[0]});
    rd(`OFS_LATCH0, {9'h0, w[1]});
    chip_enable <= 1'b0;
    settle();
    check("power", section_power, 33'h0);
    check("float", charge_pump_oe_n, 33'h1);
    chip_enable <= 1'b1;
    wr(`OFS_CTRL, 32'h08);
    settle();
    check("power", section_power, 33'h2);
    check("float", charge_pump_oe_n, 33'h1);
    for (int s = 0; s < 4; s++) begin
      wr(`OFS_CTRL, 32'h1c | s);
      r = 4'($random(seed));
      {lock_detect_in, rf_scaled_in, ref_scaled_in, pump_drive} <= r;
      settle();
      e = (s == 0) ? r[3] : (s == 1) ? r[2] : (s == 2) ? r[1] : 1'b0;
      check("mux", status_mux_output, e);
      check("pump", {charge_pump_oe_n, charge_pump_output}, {1'b0, r[0]});
      check("power", section_power, 33'h7);
    end
    close_out();
  end
endmodule : test_synth_three_wire_config_loader

// >>> three_wire_host.sv
// Host-side model that drives the three-wire serial configuration link
`timescale 1ns/1ps
module three_wire_host (
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // Clock idles low between frames; data turns to the inverse once its hold is over
  task automatic send_word(input logic [23:0] w, input logic load);
    if (w[1:0] == 2'b11) return;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #40 serial_clock = 1'b1;
      #40 serial_data = ~w[i];
      #40 serial_clock = 1'b0;
      #40;
    end
    load_strobe = load;
    #100 load_strobe = 1'b0;
  endtask : send_word
endmodule : three_wire_host

// >>> word_latch.sv
// Load-enabled holding register for one configuration word
`timescale 1ns/1ps
module word_latch #(
  parameter int W = 24
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_q <= '0;
    end else if (clk_en && load) begin
      q_q <= d;
    end
  end

  assign q = q_q;

endmodule : word_latch
